// [src/bit_sync.sv]
// Two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module bit_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------------
    // Per-bit stages; the first flop feeds only the second
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic meta_r;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_r <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    meta_r <= async_in[i];
                    sync_out[i] <= meta_r;
                end
            end
        end
    endgenerate

endmodule // bit_sync

// [src/event_status.sv]
// Sticky event status with write-one-to-clear, mask and interrupt output
`timescale 1ns/1ps
module event_status
    import fabric_irq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Events and software access
    input wire logic [EVT_W-1:0] evt_pulse,
    input wire logic clr_wr,
    input wire logic mask_wr,
    input wire logic [EVT_W-1:0] wr_data,
    // State and interrupt
    output logic [EVT_W-1:0] status_r,
    output logic [EVT_W-1:0] mask_r,
    output logic irq_r
);

    // Set wins over a clear landing in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_r <= EVT_RESET;
        end else begin
            status_r <= evt_pulse |
                        (status_r & ~(clr_wr ? wr_data : EVT_RESET));
        end
    end

    // Mask register, one enables the bit onto the interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= EVT_RESET;
        end else if (mask_wr) begin
            mask_r <= wr_data;
        end
    end

    // Level interrupt, registered so it lags status by one cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(status_r & mask_r);
        end
    end

endmodule // event_status

// [src/fabric_interrupt_mask_status.sv]
// Fabric interrupt enable and cause registers behind an APB slave
//
// Overview of operation
// - Enable-lo bit 22 gates fast DMA error
// - Enable-lo bit 17 gates NVM array 1
// - Enable-lo bit 16 gates NVM array 0
// - Enable-lo bit 15 gates subsystem PLL lost
// - Enable-lo bit 9 gates fast DMA done
// - Enable-lo bit 8 gates peripheral DMA
// - Enable-lo bit 0 gates SPI port 0
// - Enable-hi bit 7 gates wide fabric interface
// - Enable-hi bit 6 gates fabric PLL lost
// - Enable-hi bit 5 gates fabric PLL locked
// - Enable-hi bit 3 gates DDR IO calibration
// - Cause-hi bit 7 is source AND enable
// - Enable registers read/write, reset to zero
// - Cause registers read-only, reset zero, show active
//
// The APB register port and the register addresses were left to the implementer.
`timescale 1ns/1ps
module fabric_interrupt_mask_status
    import fabric_irq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Subsystem interrupt sources, asynchronous
    input wire irq_src_t irq_src,
    // Forwarded interrupts toward the fabric
    output logic [DATA_W-1:0] fabric_irq_lo,
    output logic [DATA_W-1:0] fabric_irq_hi,
    // Block interrupt
    output logic irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    irq_src_t src_sync;
    logic [DATA_W-1:0] src_lo;
    logic [DATA_W-1:0] src_hi;
    logic [DATA_W-1:0] en_lo_r;
    logic [DATA_W-1:0] en_hi_r;
    logic [DATA_W-1:0] cause_lo_r;
    logic [DATA_W-1:0] cause_hi_r;
    logic [DATA_W-1:0] cause_lo_d_r;
    logic [DATA_W-1:0] cause_hi_d_r;
    logic [DATA_W-1:0] prdata_r;
    logic [DATA_W-1:0] rd_nxt;
    logic pready_r;
    logic pslverr_r;
    logic addr_ok;
    logic access;
    logic commit_wr;
    logic [EVT_W-1:0] evt_pulse;
    logic [EVT_W-1:0] evt_status;
    logic [EVT_W-1:0] evt_mask;
    logic irq_r;

    // ------------------------------------------------------------------
    // Source synchronisation
    // ------------------------------------------------------------------
    // Sources come from other clock regions, so all are resynchronised
    bit_sync #(
        .WIDTH($bits(irq_src_t))
    ) u_src_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(irq_src),
        .sync_out(src_sync)
    );

    // Place each source at its register bit, others stay zero
    always_comb begin
        src_lo = READ_ZERO;
        src_hi = READ_ZERO;
        src_lo[BIT_FAST_DMA_ERROR] = src_sync.fast_dma_error_irq;
        src_lo[BIT_NVM_ARRAY1] = src_sync.nvm_array1_irq;
        src_lo[BIT_NVM_ARRAY0] = src_sync.nvm_array0_irq;
        src_lo[BIT_SUBSYS_PLL_LOST] = src_sync.subsys_pll_lost_irq;
        src_lo[BIT_FAST_DMA_DONE] = src_sync.fast_dma_done_irq;
        src_lo[BIT_PERIPH_DMA] = src_sync.periph_dma_irq;
        src_lo[BIT_SPI_PORT0] = src_sync.spi_port0_irq;
        src_hi[BIT_WIDE_FABRIC_IF] = src_sync.wide_fabric_if_irq;
        src_hi[BIT_FABRIC_PLL_LOST] = src_sync.fabric_pll_lost_irq;
        src_hi[BIT_FABRIC_PLL_LOCKED] = src_sync.fabric_pll_locked_irq;
        src_hi[BIT_DDR_IO_CAL] = src_sync.ddr_io_cal_irq;
    end

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // One wait state: pready rises in the second access cycle
    assign access = psel && penable;
    assign commit_wr = access && pready_r && pwrite && addr_ok;
    assign addr_ok = (paddr == OFS_ENABLE_LO) || (paddr == OFS_ENABLE_HI) ||
                     (paddr == OFS_CAUSE_LO) || (paddr == OFS_CAUSE_HI) ||
                     (paddr == OFS_EVT_STATUS) || (paddr == OFS_EVT_MASK);

    // Read multiplexer, unmapped addresses read zero
    always_comb begin
        rd_nxt = READ_ZERO;
        case (paddr)
            OFS_ENABLE_LO: rd_nxt = en_lo_r;
            OFS_ENABLE_HI: rd_nxt = en_hi_r;
            OFS_CAUSE_LO: rd_nxt = cause_lo_r;
            OFS_CAUSE_HI: rd_nxt = cause_hi_r;
            OFS_EVT_STATUS: rd_nxt[EVT_W-1:0] = evt_status;
            OFS_EVT_MASK: rd_nxt[EVT_W-1:0] = evt_mask;
            default: rd_nxt = READ_ZERO;
        endcase
    end

    // Ready handshake; drops after each completed access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= access && !pready_r;
        end
    end

    // Read data and error captured on the same edge that raises pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= READ_ZERO;
            pslverr_r <= 1'b0;
        end else if (access && !pready_r) begin
            prdata_r <= pwrite ? READ_ZERO : rd_nxt;
            pslverr_r <= !addr_ok;
        end else begin
            prdata_r <= READ_ZERO;
            pslverr_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Enable registers
    // ------------------------------------------------------------------
    // Reserved positions are masked off at write time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_lo_r <= ENABLE_RESET;
        end else if (commit_wr && paddr == OFS_ENABLE_LO) begin
            en_lo_r <= pwdata & LO_IMPL_MASK;
        end
    end

    // High enable register, same treatment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_hi_r <= ENABLE_RESET;
        end else if (commit_wr && paddr == OFS_ENABLE_HI) begin
            en_hi_r <= pwdata & HI_IMPL_MASK;
        end
    end

    // ------------------------------------------------------------------
    // Cause registers and forwarding
    // ------------------------------------------------------------------
    // Cause is a live level, not sticky; writes never reach it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_lo_r <= CAUSE_RESET;
            cause_hi_r <= CAUSE_RESET;
        end else begin
            cause_lo_r <= src_lo & en_lo_r & LO_IMPL_MASK;
            cause_hi_r <= src_hi & en_hi_r & HI_IMPL_MASK;
        end
    end

    // Delayed copy for rising-edge detection of the causes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cause_lo_d_r <= CAUSE_RESET;
            cause_hi_d_r <= CAUSE_RESET;
        end else begin
            cause_lo_d_r <= cause_lo_r;
            cause_hi_d_r <= cause_hi_r;
        end
    end

    // A newly active cause in either register raises its event
    always_comb begin
        evt_pulse = EVT_RESET;
        evt_pulse[EVT_LO] = |(cause_lo_r & ~cause_lo_d_r);
        evt_pulse[EVT_HI] = |(cause_hi_r & ~cause_hi_d_r);
    end

    // ------------------------------------------------------------------
    // Event status and block interrupt
    // ------------------------------------------------------------------
    event_status u_evt (
        .pclk(pclk),
        .presetn(presetn),
        .evt_pulse(evt_pulse),
        .clr_wr(commit_wr && paddr == OFS_EVT_STATUS),
        .mask_wr(commit_wr && paddr == OFS_EVT_MASK),
        .wr_data(pwdata[EVT_W-1:0]),
        .status_r(evt_status),
        .mask_r(evt_mask),
        .irq_r(irq_r)
    );

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign fabric_irq_lo = cause_lo_r;
    assign fabric_irq_hi = cause_hi_r;
    assign irq = irq_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_wr_lo;
        psel && penable && pready && pwrite && paddr == OFS_ENABLE_LO;
    endsequence

    sequence s_wr_hi;
        psel && penable && pready && pwrite && paddr == OFS_ENABLE_HI;
    endsequence

    sequence s_rd_start(logic [APB_ADDR_W-1:0] a);
        psel && penable && !pready && !pwrite && paddr == a;
    endsequence

    // Cause bit follows source and enable one cycle later
    property p_gate_lo(int b);
        @(posedge pclk) disable iff (!presetn)
        cause_lo_r[b] == $past(src_lo[b] && en_lo_r[b]);
    endproperty

    property p_gate_hi(int b);
        @(posedge pclk) disable iff (!presetn)
        cause_hi_r[b] == $past(src_hi[b] && en_hi_r[b]);
    endproperty

    a_fast_dma_error: assert property (p_gate_lo(BIT_FAST_DMA_ERROR))
        else $error("fast dma error cause mismatch");
    a_nvm_array1: assert property (p_gate_lo(BIT_NVM_ARRAY1))
        else $error("nvm array1 cause mismatch");
    a_nvm_array0: assert property (p_gate_lo(BIT_NVM_ARRAY0))
        else $error("nvm array0 cause mismatch");
    a_subsys_pll_lost: assert property (p_gate_lo(BIT_SUBSYS_PLL_LOST))
        else $error("subsystem pll lost cause mismatch");
    a_fast_dma_done: assert property (p_gate_lo(BIT_FAST_DMA_DONE))
        else $error("fast dma done cause mismatch");
    a_periph_dma: assert property (p_gate_lo(BIT_PERIPH_DMA))
        else $error("peripheral dma cause mismatch");
    a_spi_port0: assert property (p_gate_lo(BIT_SPI_PORT0))
        else $error("spi port0 cause mismatch");
    a_wide_fabric_if: assert property (p_gate_hi(BIT_WIDE_FABRIC_IF))
        else $error("wide fabric interface cause mismatch");
    a_fabric_pll_lost: assert property (p_gate_hi(BIT_FABRIC_PLL_LOST))
        else $error("fabric pll lost cause mismatch");
    a_pll_locked_gate: assert property (p_gate_hi(BIT_FABRIC_PLL_LOCKED))
        else $error("fabric pll locked cause mismatch");
    a_ddr_io_cal: assert property (p_gate_hi(BIT_DDR_IO_CAL))
        else $error("ddr io calibration cause mismatch");

    // Source masked for two cycles never shows, even with the source held high
    a_wide_if_masked: assert property (
        @(posedge pclk) disable iff (!presetn)
        (!en_hi_r[BIT_WIDE_FABRIC_IF]) [*2] |-> !cause_hi_r[BIT_WIDE_FABRIC_IF])
        else $error("wide fabric cause set while masked");

    // Write to enable-lo lands in the register next cycle
    a_enable_lo_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_lo |=> en_lo_r == ($past(pwdata) & LO_IMPL_MASK))
        else $error("enable lo write not stored");

    // Write to enable-hi lands in the register next cycle
    a_enable_hi_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_wr_hi |=> en_hi_r == ($past(pwdata) & HI_IMPL_MASK))
        else $error("enable hi write not stored");

    // Enable-hi holds unless written
    a_enable_hi_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !(psel && penable && pready && pwrite && paddr == OFS_ENABLE_HI)
        |=> $stable(en_hi_r))
        else $error("enable hi changed without write");

    // Reading enable-lo returns its value when pready rises
    a_enable_lo_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_start(OFS_ENABLE_LO) |=> pready && prdata == $past(en_lo_r))
        else $error("enable lo read data wrong");

    // Reading cause-hi returns its live value when pready rises
    a_cause_hi_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_rd_start(OFS_CAUSE_HI) |=> pready && prdata == $past(cause_hi_r))
        else $error("cause hi read data wrong");

    // Cause-hi keeps following source and enable on a write to its offset
    a_cause_read_only: assert property (
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && pready && pwrite && paddr == OFS_CAUSE_HI)
        |=> cause_hi_r == ($past(src_hi) & $past(en_hi_r) & HI_IMPL_MASK))
        else $error("cause hi disturbed by write");

    // Reserved bits stay zero everywhere
    a_reserved_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((en_lo_r | cause_lo_r) & ~LO_IMPL_MASK) == READ_ZERO &&
        ((en_hi_r | cause_hi_r) & ~HI_IMPL_MASK) == READ_ZERO)
        else $error("reserved bit set");

    // Answer arrives on the second access cycle and lasts one cycle
    a_apb_one_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        $rose(psel && penable) ##0 !pready |=> pready ##1 !pready)
        else $error("apb answer timing wrong");

    // Unmapped access reports an error with its answer
    a_apb_unmapped: assert property (
        @(posedge pclk) disable iff (!presetn)
        (access && !pready && !addr_ok) |=> pready && pslverr)
        else $error("unmapped access not flagged");

    // New high-side cause reaches the interrupt within two cycles when unmasked
    a_irq_follows: assert property (
        @(posedge pclk) disable iff (!presetn)
        (evt_pulse[EVT_HI] && evt_mask[EVT_HI] && !commit_wr)
        |-> ##[1:2] irq)
        else $error("interrupt did not follow event");

endmodule // fabric_interrupt_mask_status

// [src/fabric_irq_pkg.sv]
// Constants, register map and carriers for the fabric interrupt mask block
package fabric_irq_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int APB_ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam logic [APB_ADDR_W-1:0] OFS_ENABLE_LO = 12'h000;
    localparam logic [APB_ADDR_W-1:0] OFS_ENABLE_HI = 12'h004;
    localparam logic [APB_ADDR_W-1:0] OFS_CAUSE_LO = 12'h008;
    localparam logic [APB_ADDR_W-1:0] OFS_CAUSE_HI = 12'h00c;
    localparam logic [APB_ADDR_W-1:0] OFS_EVT_STATUS = 12'h020;
    localparam logic [APB_ADDR_W-1:0] OFS_EVT_MASK = 12'h024;
    localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CAUSE_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] READ_ZERO = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Bit positions in the low enable and cause registers
    // ------------------------------------------------------------------
    localparam int BIT_FAST_DMA_ERROR = 22;
    localparam int BIT_NVM_ARRAY1 = 17;
    localparam int BIT_NVM_ARRAY0 = 16;
    localparam int BIT_SUBSYS_PLL_LOST = 15;
    localparam int BIT_FAST_DMA_DONE = 9;
    localparam int BIT_PERIPH_DMA = 8;
    localparam int BIT_SPI_PORT0 = 0;
    localparam logic [DATA_W-1:0] LO_IMPL_MASK = 32'h0043_8301;

    // ------------------------------------------------------------------
    // Bit positions in the high enable and cause registers
    // ------------------------------------------------------------------
    localparam int BIT_WIDE_FABRIC_IF = 7;
    localparam int BIT_FABRIC_PLL_LOST = 6;
    localparam int BIT_FABRIC_PLL_LOCKED = 5;
    localparam int BIT_DDR_IO_CAL = 3;
    localparam logic [DATA_W-1:0] HI_IMPL_MASK = 32'h0000_00e8;

    // ------------------------------------------------------------------
    // Event status layout
    // ------------------------------------------------------------------
    localparam int EVT_W = 2;
    localparam int EVT_LO = 0;
    localparam int EVT_HI = 1;
    localparam logic [EVT_W-1:0] EVT_RESET = 2'h0;

    // Raw interrupt lines from the on-chip subsystems
    typedef struct packed {
        logic fast_dma_error_irq;
        logic nvm_array1_irq;
        logic nvm_array0_irq;
        logic subsys_pll_lost_irq;
        logic fast_dma_done_irq;
        logic periph_dma_irq;
        logic spi_port0_irq;
        logic wide_fabric_if_irq;
        logic fabric_pll_lost_irq;
        logic fabric_pll_locked_irq;
        logic ddr_io_cal_irq;
    } irq_src_t;

endpackage

// [tb/fabric_sink.sv]
// Fabric-side model that latches every forwarded interrupt it receives
`timescale 1ns/1ps
module fabric_sink
    import fabric_irq_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Forwarded interrupts and latch clear
    input wire logic [DATA_W-1:0] fabric_irq_lo,
    input wire logic [DATA_W-1:0] fabric_irq_hi,
    input wire logic seen_clr,
    // Latched view of what reached the fabric
    output logic [DATA_W-1:0] seen_lo_r,
    output logic [DATA_W-1:0] seen_hi_r
);
    // Sticky capture, so a one-cycle pulse on an unmasked line is not missed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_lo_r <= '0;
            seen_hi_r <= '0;
        end else if (seen_clr) begin
            seen_lo_r <= '0;
            seen_hi_r <= '0;
        end else begin
            seen_lo_r <= seen_lo_r | fabric_irq_lo;
            seen_hi_r <= seen_hi_r | fabric_irq_hi;
        end
    end
endmodule // fabric_sink

// [tb/test_fabric_interrupt_mask_status.sv]
// Self-checking bench for the fabric interrupt enable and cause registers
`timescale 1ns/1ps
module test_fabric_interrupt_mask_status
    import fabric_irq_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic seen_clr;
    logic [APB_ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, fabric_irq_lo, fabric_irq_hi;
    logic [DATA_W-1:0] seen_lo, seen_hi, rd, en_lo, en_hi;
    logic err;
    irq_src_t irq_src;
    int mismatches, samples_checked;

    fabric_interrupt_mask_status dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_src(irq_src),
        .fabric_irq_lo(fabric_irq_lo), .fabric_irq_hi(fabric_irq_hi),
        .irq(irq));
    fabric_sink sink (.pclk(pclk), .presetn(presetn),
        .fabric_irq_lo(fabric_irq_lo), .fabric_irq_hi(fabric_irq_hi),
        .seen_clr(seen_clr), .seen_lo_r(seen_lo), .seen_hi_r(seen_hi));

    // Free-running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ------------------------------------------------------------------
    // Checking and verdict
    // ------------------------------------------------------------------
    task automatic check(input logic [DATA_W-1:0] seen,
                         input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Expected forwarded words: source AND enable at the documented bits
    function automatic logic [DATA_W-1:0] exp_lo(irq_src_t s,
                                                 logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] r;
        r = '0;
        r[BIT_FAST_DMA_ERROR] = s.fast_dma_error_irq;
        r[BIT_NVM_ARRAY1] = s.nvm_array1_irq;
        r[BIT_NVM_ARRAY0] = s.nvm_array0_irq;
        r[BIT_SUBSYS_PLL_LOST] = s.subsys_pll_lost_irq;
        r[BIT_FAST_DMA_DONE] = s.fast_dma_done_irq;
        r[BIT_PERIPH_DMA] = s.periph_dma_irq;
        r[BIT_SPI_PORT0] = s.spi_port0_irq;
        return r & e & LO_IMPL_MASK;
    endfunction

    function automatic logic [DATA_W-1:0] exp_hi(irq_src_t s,
                                                 logic [DATA_W-1:0] e);
        logic [DATA_W-1:0] r;
        r = '0;
        r[BIT_WIDE_FABRIC_IF] = s.wide_fabric_if_irq;
        r[BIT_FABRIC_PLL_LOST] = s.fabric_pll_lost_irq;
        r[BIT_FABRIC_PLL_LOCKED] = s.fabric_pll_locked_irq;
        r[BIT_DDR_IO_CAL] = s.ddr_io_cal_irq;
        return r & e & HI_IMPL_MASK;
    endfunction

    // ------------------------------------------------------------------
    // APB master: hold the request until pready is sampled high
    // ------------------------------------------------------------------
    task automatic apb(input logic wr, input logic [APB_ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd,
                       output logic [DATA_W-1:0] d, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // No cycle count assumed; only the watchdog ends a stuck wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        d = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [APB_ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] wd);
        logic [DATA_W-1:0] d;
        logic e;
        apb(1'b1, a, wd, d, e);
    endtask

    task automatic rd_chk(input logic [APB_ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] exp, input logic xerr);
        logic e;
        apb(1'b0, a, '0, rd, e);
        check(rd, exp);
        check({31'h0, e}, {31'h0, xerr});
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Watchdog sized well above the roughly 1200 cycles the tests need
    initial begin
        #400us;
        mismatches++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [APB_ADDR_W-1:0] bad [4];
        bad = '{12'h010, 12'h014, 12'h002, 12'hffc};
        mismatches = 0;
        samples_checked = 0;
        presetn = 1'b0;
        {psel, penable, pwrite, seen_clr} = '0;
        paddr = '0;
        pwdata = '0;
        irq_src = '0;
        wait_cyc(3);
        presetn <= 1'b1;
        void'($urandom(32'h06e4b504));

        // Reset values, then write-ones readback, then read-only cause
        rd_chk(OFS_ENABLE_LO, ENABLE_RESET, 1'b0);
        rd_chk(OFS_ENABLE_HI, ENABLE_RESET, 1'b0);
        rd_chk(OFS_CAUSE_LO, CAUSE_RESET, 1'b0);
        rd_chk(OFS_CAUSE_HI, CAUSE_RESET, 1'b0);
        wr(OFS_ENABLE_LO, 32'hffff_ffff);
        wr(OFS_ENABLE_HI, 32'hffff_ffff);
        wr(OFS_CAUSE_LO, 32'hffff_ffff);
        wr(OFS_CAUSE_HI, 32'hffff_ffff);
        rd_chk(OFS_ENABLE_LO, LO_IMPL_MASK, 1'b0);
        rd_chk(OFS_ENABLE_HI, HI_IMPL_MASK, 1'b0);
        rd_chk(OFS_CAUSE_LO, CAUSE_RESET, 1'b0);
        rd_chk(OFS_CAUSE_HI, CAUSE_RESET, 1'b0);
        foreach (bad[i]) rd_chk(bad[i], READ_ZERO, 1'b1);
        $display("test registers done");

        // Gating: all-on and all-masked corners, then random mixes
        for (int i = 0; i < 40; i++) begin
            en_lo = (i == 0) ? 32'hffff_ffff : (i == 1) ? '0 : $urandom;
            en_hi = (i == 0) ? 32'hffff_ffff : (i == 1) ? '0 : $urandom;
            wr(OFS_ENABLE_LO, en_lo);
            wr(OFS_ENABLE_HI, en_hi);
            @(posedge pclk);
            irq_src <= (i < 2) ? irq_src_t'(11'h7ff) : irq_src_t'($urandom);
            wait_cyc(5);
            seen_clr <= 1'b1;
            @(posedge pclk);
            seen_clr <= 1'b0;
            wait_cyc(3);
            check(fabric_irq_lo, exp_lo(irq_src, en_lo));
            check(fabric_irq_hi, exp_hi(irq_src, en_hi));
            check(seen_lo, exp_lo(irq_src, en_lo));
            check(seen_hi, exp_hi(irq_src, en_hi));
            rd_chk(OFS_CAUSE_LO, exp_lo(irq_src, en_lo), 1'b0);
            rd_chk(OFS_CAUSE_HI, exp_hi(irq_src, en_hi), 1'b0);
        end
        $display("test gating done");

        // Event status: raise, mask, clear by writing one
        wr(OFS_ENABLE_LO, 32'hffff_ffff);
        wr(OFS_ENABLE_HI, 32'hffff_ffff);
        irq_src <= '0;
        wait_cyc(6);
        wr(OFS_EVT_STATUS, 32'h0000_0003);
        wr(OFS_EVT_MASK, 32'h0000_0003);
        wait_cyc(3);
        rd_chk(OFS_EVT_STATUS, 32'h0, 1'b0);
        check({31'h0, irq}, 32'h0);
        irq_src.spi_port0_irq <= 1'b1;
        wait_cyc(6);
        check({31'h0, irq}, 32'h1);
        rd_chk(OFS_EVT_STATUS, 32'h1, 1'b0);
        wr(OFS_EVT_STATUS, 32'h0000_0001);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0);
        wr(OFS_EVT_MASK, 32'h0000_0000);
        irq_src.wide_fabric_if_irq <= 1'b1;
        wait_cyc(6);
        check({31'h0, irq}, 32'h0);
        rd_chk(OFS_EVT_STATUS, 32'h2, 1'b0);
        rd_chk(OFS_EVT_MASK, 32'h0, 1'b0);
        wr(OFS_EVT_MASK, 32'h0000_0002);
        wait_cyc(3);
        check({31'h0, irq}, 32'h1);
        wr(OFS_EVT_STATUS, 32'h0000_0002);
        wait_cyc(3);
        check({31'h0, irq}, 32'h0);
        // New high-side edge while unmasked must raise the interrupt
        irq_src.wide_fabric_if_irq <= 1'b0;
        wait_cyc(4);
        irq_src.wide_fabric_if_irq <= 1'b1;
        wait_cyc(6);
        check({31'h0, irq}, 32'h1);
        $display("test interrupt done");
        print_verdict();
    end
endmodule // test_fabric_interrupt_mask_status
